// File: core/fcse_consts.svh
// Constants of the flash command and status engine: command bytes, status bits, timing.
// Assumes a 25 MHz core clock; included by bare name from the core files.
`ifndef FCSE_CONSTS_SVH
`define FCSE_CONSTS_SVH

`define FCSE_CMD_READ_ARRAY   8'hff
`define FCSE_CMD_ERASE_UNIF   8'h20
`define FCSE_CMD_ERASE_FINE   8'h21
`define FCSE_CMD_CONFIRM      8'hd0
`define FCSE_CMD_PROG_A       8'h40
`define FCSE_CMD_PROG_B       8'h10
`define FCSE_CMD_READ_STATUS  8'h70
`define FCSE_CMD_CLEAR_STATUS 8'h50
`define FCSE_CMD_READ_ID      8'h90

`define FCSE_SR_READY         7
`define FCSE_SR_ERASE_FAIL    5
`define FCSE_SR_PROG_FAIL     4
`define FCSE_SR_PROTECT       1
`define FCSE_SR_RESERVED_MASK 8'h4d

`define FCSE_ID_MFR_ADDR      19'h00000
`define FCSE_ID_DEV_ADDR      19'h00001
`define FCSE_TOP_SECTOR       4'ha
`define FCSE_SUB_FIRST        19'h00000
`define FCSE_SUB_LAST         19'h0ffff

`define FCSE_SER_WRITE_CYC    17
`define FCSE_SER_READ_CYC     19
`define FCSE_CLK_MHZ          25
`define FCSE_PROG_TIME_US     20
`define FCSE_PROG_CYC         (`FCSE_PROG_TIME_US * `FCSE_CLK_MHZ)

`endif

// File: core/fcse_pkg.sv
// Types shared by the flash command and status engine.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package fcse_pkg;
  typedef enum logic [1:0] {
    FCSE_READ_ARRAY  = 2'b00,
    FCSE_READ_STATUS = 2'b01,
    FCSE_READ_ID     = 2'b10
  } fcse_mode_t;
  typedef enum logic [1:0] {
    FCSE_PEND_NONE = 2'b00,
    FCSE_PEND_FINE = 2'b01,
    FCSE_PEND_UNIF = 2'b10,
    FCSE_PEND_PROG = 2'b11
  } fcse_pend_t;
  typedef enum logic [1:0] {
    FCSE_SEQ_IDLE      = 2'b00,
    FCSE_SEQ_PROG_RD   = 2'b01,
    FCSE_SEQ_PROG_RUN  = 2'b10,
    FCSE_SEQ_ERASE_RUN = 2'b11
  } fcse_seq_t;
endpackage
`default_nettype wire

// File: core/fcse_sector_map.sv
// Maps a byte address to its sector number and that sector's first and last address.
// Assumes a 19-bit address; sectors 0 to 3 fill the bottom 64 Kbyte, 4 to 10 above.
`default_nettype none
module fcse_sector_map (
  // Address in.
  input  wire logic [18:0] addr,
  // Sector out.
  output logic      [3:0]  sector,
  output logic             is_sub,
  output logic      [18:0] first,
  output logic      [18:0] last
);
  always_comb begin
    is_sub = (addr[18:16] == 3'h0);
    if (!is_sub) begin
      sector = {1'b0, addr[18:16]} + 4'h3;
      first  = {addr[18:16], 16'h0000};
      last   = {addr[18:16], 16'hffff};
    end else if (addr[15]) begin
      sector = 4'h3;
      first  = 19'h08000;
      last   = 19'h0ffff;
    end else if (addr[14]) begin
      sector = 4'h2;
      first  = 19'h04000;
      last   = 19'h07fff;
    end else if (addr[13]) begin
      sector = 4'h1;
      first  = 19'h02000;
      last   = 19'h03fff;
    end else begin
      sector = 4'h0;
      first  = 19'h00000;
      last   = 19'h01fff;
    end
  end
endmodule // fcse_sector_map
`default_nettype wire

// File: core/fcse_gap_timer.sv
// Down counter that holds off the serial port for the length of one bus cycle.
// Assumes load is a one-cycle pulse taken only while idle.
`default_nettype none
module fcse_gap_timer #(
  parameter int CW = 5
) (
  // Clock and reset.
  input  wire logic          clock,
  input  wire logic          reset,
  // Control.
  input  wire logic          load,
  input  wire logic [CW-1:0] load_value,
  output logic               idle
);
  typedef struct packed {
    logic [CW-1:0] count;
  } fcse_gap_t;

  fcse_gap_t st;
  fcse_gap_t next_st;

  if (CW < 5) begin : g_bad_width
    $error("fcse_gap_timer: CW too small for a 19-cycle gap.");
  end

  assign idle = (st.count == '0);

  always_comb begin
    next_st = st;
    if (load) begin
      next_st.count = load_value;
    end else if (!idle) begin
      next_st.count = st.count - 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
endmodule // fcse_gap_timer
`default_nettype wire

// File: core/fcse_top.sv
// Command decoder, operation sequencer and status register of a BIOS flash.
// Assumes deframed byte cycles on both ports and a combinational array read.
//
// What this block does
// - Both ports deliver command bytes that decode identically.
// - A serial write cycle takes 17 bus clocks before the next.
// - A serial read cycle takes 19 bus clocks before the next.
// - After reset the block is in array-read mode.
// - Write of FFH selects array-read mode.
// - FFH is ignored while an erase or program runs.
// - Erase needs 21H or 20H then D0H inside the target sector.
// - Fine erase clears only the addressed sector.
// - Uniform erase of a sub-sector erases all four; main sector alone.
// - Uniform sub-sector erase needs all four unlocked and protect pin inactive.
// - Erase sets every bit of the range to one.
// - Program is 40H or 10H then address and data, self-timed.
// - Programming only clears bits.
// - Locked or pin-protected sectors refuse erase and program, flagged in status.
// - Erase or program leaves the block in status-read mode.
// - Write of 70H makes every read return status, even while busy.
// - Flags 5, 4 and 1 set only by the command decode, cleared by 50H.
// - Status bit 7 is low while busy, high when ready.
// - Bit 5 erase failure, bit 4 program failure, both sequence error.
// - Bit 1 is set by any refused protected target and holds until 50H.
// - After 90H reads of address 0 and 1 return the two ID codes.
// - Any valid command is acted on from ID mode; all but 50H and 90H leave ID mode.
// - The ready/busy pin is pulled low for the whole operation.
`default_nettype none
`include "fcse_consts.svh"
module fcse_top #(
  parameter int         ERASE_TIME_US = 10000,
  parameter int         OP_CW         = 20,
  parameter logic [7:0] MFR_CODE      = 8'h5a,
  parameter logic [7:0] DEV_CODE      = 8'h3c
) (
  // Clock and reset.
  input  wire logic                 clock,
  input  wire logic                 reset,
  // Parallel programming port.
  input  wire logic                 par_write,
  input  wire logic                 par_read,
  input  wire logic [18:0]          par_addr,
  input  wire logic [7:0]           par_wdata,
  // Serial bus port.
  input  wire logic                 ser_write,
  input  wire logic                 ser_read,
  input  wire logic [18:0]          ser_addr,
  input  wire logic [7:0]           ser_wdata,
  // Read answer.
  output logic                      read_valid,
  output logic [7:0]                read_data,
  output fcse_pkg::fcse_mode_t      read_mode,
  // Protection inputs.
  input  wire logic [10:0]          write_lock,
  input  wire logic                 top_boot_protect_pin_n,
  input  wire logic                 general_protect_pin_n,
  // Array access.
  output logic [18:0]               array_addr,
  input  wire logic [7:0]           array_rdata,
  output logic                      array_prog,
  output logic [7:0]                array_wdata,
  output logic                      array_erase,
  output logic [18:0]               array_erase_first,
  output logic [18:0]               array_erase_last,
  // Open-drain ready/busy pin.
  output logic                      ready_busy_output_o,
  output logic                      ready_busy_output_oe
);
  import fcse_pkg::*;

  localparam int ERASE_CYC = ERASE_TIME_US * `FCSE_CLK_MHZ;

  if (ERASE_CYC < 1 || ERASE_CYC >= (1 << OP_CW) || `FCSE_PROG_CYC >= (1 << OP_CW))
  begin : g_bad_count
    $error("fcse_top: OP_CW cannot hold the operation times.");
  end

  typedef struct packed {
    fcse_mode_t       mode;
    fcse_pend_t       pend;
    fcse_seq_t        seq;
    logic [7:0]       prog_data;
    logic [OP_CW-1:0] op_count;
    logic             sr_erase;
    logic             sr_prog;
    logic             sr_prot;
    logic             rd_pend;
    logic             read_valid;
    logic [7:0]       read_data;
    logic [18:0]      array_addr;
    logic [7:0]       array_wdata;
    logic             array_prog;
    logic             array_erase;
    logic [18:0]      erase_first;
    logic [18:0]      erase_last;
    logic             rb_oe;
  } fcse_state_t;

  fcse_state_t st;
  fcse_state_t next_st;

  ////////////////////////////////////////////////////////////////////////////////
  // Port selection and serial spacing.

  logic        gap_idle;
  logic        ser_w_take;
  logic        ser_r_take;
  logic        wr_take;
  logic        rd_take;
  logic [18:0] wr_addr;
  logic [7:0]  wr_data;
  logic [18:0] rd_addr;
  logic [4:0]  gap_load_value;

  // The parallel port wins a tie; a serial strobe inside the gap is dropped.
  assign ser_w_take = ser_write && gap_idle && !par_write;
  assign ser_r_take = ser_read && gap_idle && !ser_write && !par_read;
  assign wr_take    = par_write || ser_w_take;
  assign rd_take    = par_read || ser_r_take;
  assign wr_addr    = par_write ? par_addr : ser_addr;
  assign wr_data    = par_write ? par_wdata : ser_wdata;
  assign rd_addr    = par_read ? par_addr : ser_addr;
  assign gap_load_value = ser_w_take ? 5'(`FCSE_SER_WRITE_CYC - 1)
                                     : 5'(`FCSE_SER_READ_CYC - 1);

  fcse_gap_timer #(
    .CW(5)
  ) u_gap (
    .clock     (clock),
    .reset     (reset),
    .load      (ser_w_take || ser_r_take),
    .load_value(gap_load_value),
    .idle      (gap_idle)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Target sector and its protection.

  logic [3:0]  tgt_sector;
  logic        tgt_is_sub;
  logic [18:0] tgt_first;
  logic [18:0] tgt_last;
  logic        tgt_prot;
  logic        sub_prot;

  fcse_sector_map u_map (
    .addr  (wr_addr),
    .sector(tgt_sector),
    .is_sub(tgt_is_sub),
    .first (tgt_first),
    .last  (tgt_last)
  );

  // The top sector answers to its own pin, every other sector to the general pin.
  assign tgt_prot = write_lock[tgt_sector] ||
                    ((tgt_sector == `FCSE_TOP_SECTOR) ? !top_boot_protect_pin_n
                                                      : !general_protect_pin_n);
  assign sub_prot = (|write_lock[3:0]) || !general_protect_pin_n;

  ////////////////////////////////////////////////////////////////////////////////
  // Decode, sequencer and status.

  logic       busy;
  logic       clr_take;
  logic [7:0] status_byte;

  assign busy     = (st.seq != FCSE_SEQ_IDLE);
  assign clr_take = wr_take && !busy && st.pend == FCSE_PEND_NONE &&
                    wr_data == `FCSE_CMD_CLEAR_STATUS;
  // Only bits 7, 5, 4 and 1 carry anything.
  always_comb begin
    status_byte = 8'h00;
    status_byte[`FCSE_SR_READY]      = !busy;
    status_byte[`FCSE_SR_ERASE_FAIL] = st.sr_erase;
    status_byte[`FCSE_SR_PROG_FAIL]  = st.sr_prog;
    status_byte[`FCSE_SR_PROTECT]    = st.sr_prot;
  end

  always_comb begin
    next_st             = st;
    next_st.array_prog  = 1'b0;
    next_st.array_erase = 1'b0;
    next_st.read_valid  = st.rd_pend;
    next_st.rd_pend     = rd_take;

    // Read answer, one cycle after the address reached the array.
    if (st.rd_pend) begin
      unique case (st.mode)
        FCSE_READ_ARRAY:  next_st.read_data = array_rdata;
        FCSE_READ_STATUS: next_st.read_data = status_byte;
        FCSE_READ_ID: begin
          if (st.array_addr == `FCSE_ID_MFR_ADDR) begin
            next_st.read_data = MFR_CODE;
          end else if (st.array_addr == `FCSE_ID_DEV_ADDR) begin
            next_st.read_data = DEV_CODE;
          end else begin
            next_st.read_data = 8'h00;
          end
        end
        default: next_st.read_data = 8'h00;
      endcase
    end
    if (rd_take && !busy) begin
      next_st.array_addr = rd_addr;
    end

    // Sequencer.
    unique case (st.seq)
      FCSE_SEQ_IDLE: begin
      end
      FCSE_SEQ_PROG_RD: begin
        next_st.array_wdata = array_rdata & st.prog_data;
        next_st.array_prog  = 1'b1;
        next_st.op_count    = OP_CW'(`FCSE_PROG_CYC - 1);
        next_st.seq         = FCSE_SEQ_PROG_RUN;
      end
      FCSE_SEQ_PROG_RUN, FCSE_SEQ_ERASE_RUN: begin
        if (st.op_count == '0) begin
          next_st.seq = FCSE_SEQ_IDLE;
        end else begin
          next_st.op_count = st.op_count - 1'b1;
        end
      end
    endcase

    // Command writes. Flags are set only here, never in the cycle of a clear.
    if (wr_take && busy) begin
      if (wr_data == `FCSE_CMD_READ_STATUS) begin
        next_st.mode = FCSE_READ_STATUS;
      end
    end else if (wr_take && st.pend == FCSE_PEND_PROG) begin
      next_st.pend = FCSE_PEND_NONE;
      next_st.mode = FCSE_READ_STATUS;
      if (tgt_prot) begin
        next_st.sr_prog = 1'b1;
        next_st.sr_prot = 1'b1;
      end else begin
        next_st.array_addr = wr_addr;
        next_st.prog_data  = wr_data;
        next_st.seq        = FCSE_SEQ_PROG_RD;
      end
    end else if (wr_take && st.pend != FCSE_PEND_NONE) begin
      next_st.pend = FCSE_PEND_NONE;
      next_st.mode = FCSE_READ_STATUS;
      if (wr_data != `FCSE_CMD_CONFIRM) begin
        next_st.sr_erase = 1'b1;
        next_st.sr_prog  = 1'b1;
      end else if (st.pend == FCSE_PEND_UNIF && tgt_is_sub) begin
        if (sub_prot) begin
          next_st.sr_erase = 1'b1;
          next_st.sr_prot  = 1'b1;
        end else begin
          next_st.erase_first = `FCSE_SUB_FIRST;
          next_st.erase_last  = `FCSE_SUB_LAST;
          next_st.array_erase = 1'b1;
          next_st.op_count    = OP_CW'(ERASE_CYC - 1);
          next_st.seq         = FCSE_SEQ_ERASE_RUN;
        end
      end else if (tgt_prot) begin
        next_st.sr_erase = 1'b1;
        next_st.sr_prot  = 1'b1;
      end else begin
        next_st.erase_first = tgt_first;
        next_st.erase_last  = tgt_last;
        next_st.array_erase = 1'b1;
        next_st.op_count    = OP_CW'(ERASE_CYC - 1);
        next_st.seq         = FCSE_SEQ_ERASE_RUN;
      end
    end else if (wr_take) begin
      unique case (wr_data)
        `FCSE_CMD_READ_ARRAY:  next_st.mode = FCSE_READ_ARRAY;
        `FCSE_CMD_READ_STATUS: next_st.mode = FCSE_READ_STATUS;
        `FCSE_CMD_READ_ID:     next_st.mode = FCSE_READ_ID;
        `FCSE_CMD_ERASE_FINE: begin
          next_st.pend = FCSE_PEND_FINE;
          next_st.mode = FCSE_READ_STATUS;
        end
        `FCSE_CMD_ERASE_UNIF: begin
          next_st.pend = FCSE_PEND_UNIF;
          next_st.mode = FCSE_READ_STATUS;
        end
        `FCSE_CMD_PROG_A, `FCSE_CMD_PROG_B: begin
          next_st.pend = FCSE_PEND_PROG;
          next_st.mode = FCSE_READ_STATUS;
        end
        `FCSE_CMD_CLEAR_STATUS: begin
          next_st.sr_erase = 1'b0;
          next_st.sr_prog  = 1'b0;
          next_st.sr_prot  = 1'b0;
        end
        default: begin
        end
      endcase
    end

    next_st.rb_oe = (next_st.seq != FCSE_SEQ_IDLE);
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      st      <= '0;
      st.mode <= FCSE_READ_ARRAY;
    end else begin
      st <= next_st;
    end
  end

  assign read_valid           = st.read_valid;
  assign read_data            = st.read_data;
  assign read_mode            = st.mode;
  assign array_addr           = st.array_addr;
  assign array_prog           = st.array_prog;
  assign array_wdata          = st.array_wdata;
  assign array_erase          = st.array_erase;
  assign array_erase_first    = st.erase_first;
  assign array_erase_last     = st.erase_last;
  assign ready_busy_output_o  = 1'b0;
  assign ready_busy_output_oe = st.rb_oe;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks.

  property p_read_answer;
    @(posedge clock) disable iff (reset) rd_take |-> ##2 read_valid;
  endproperty
  a_read_answer: assert property (p_read_answer) else $error("read not answered");

  property p_ser_write_gap;
    @(posedge clock) disable iff (reset) ser_w_take |-> ##16 !gap_idle ##1 gap_idle;
  endproperty
  a_ser_write_gap: assert property (p_ser_write_gap) else $error("serial write gap");

  property p_ser_read_gap;
    @(posedge clock) disable iff (reset) ser_r_take |-> ##18 !gap_idle ##1 gap_idle;
  endproperty
  a_ser_read_gap: assert property (p_ser_read_gap) else $error("serial read gap");

  property p_array_mode;
    @(posedge clock) disable iff (reset)
      (wr_take && !busy && st.pend == FCSE_PEND_NONE && wr_data == `FCSE_CMD_READ_ARRAY)
      |=> read_mode == FCSE_READ_ARRAY;
  endproperty
  a_array_mode: assert property (p_array_mode) else $error("FFH not taken");

  property p_busy_ignores_ff;
    @(posedge clock) disable iff (reset)
      (busy && wr_take && wr_data == `FCSE_CMD_READ_ARRAY) |=> read_mode != FCSE_READ_ARRAY;
  endproperty
  a_busy_ignores_ff: assert property (p_busy_ignores_ff) else $error("FFH taken while busy");

  property p_seq_error;
    @(posedge clock) disable iff (reset)
      (wr_take && !busy && (st.pend == FCSE_PEND_FINE || st.pend == FCSE_PEND_UNIF) &&
       wr_data != `FCSE_CMD_CONFIRM) |=> st.sr_erase && st.sr_prog && !array_erase;
  endproperty
  a_seq_error: assert property (p_seq_error) else $error("sequence error not flagged");

  property p_flag_clear_only;
    @(posedge clock) disable iff (reset)
      ($fell(st.sr_erase) || $fell(st.sr_prog) || $fell(st.sr_prot)) |-> $past(clr_take);
  endproperty
  a_flag_clear_only: assert property (p_flag_clear_only) else $error("flag cleared");

  property p_pin_busy;
    @(posedge clock) disable iff (reset) ready_busy_output_oe == busy;
  endproperty
  a_pin_busy: assert property (p_pin_busy) else $error("ready/busy pin wrong");

  property p_prog_clears_only;
    @(posedge clock) disable iff (reset)
      array_prog |-> (array_wdata & ~$past(array_rdata)) == 8'h00;
  endproperty
  a_prog_clears_only: assert property (p_prog_clears_only) else $error("bit raised");

  property p_reserved_zero;
    @(posedge clock) disable iff (reset)
      (st.rd_pend && st.mode == FCSE_READ_STATUS)
      |=> (read_data & `FCSE_SR_RESERVED_MASK) == 8'h00;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit set");

endmodule // fcse_top
`default_nettype wire

// File: bench/fcse_array_model.sv
// Behavioural flash array behind the engine: combinational read, byte write, range erase.
// Assumes array_prog and array_erase are one-cycle pulses sampled on the rising edge.
`default_nettype none
module fcse_array_model (
  // Clock.
  input  wire logic        clock,
  // Array access.
  input  wire logic [18:0] array_addr,
  output logic      [7:0]  array_rdata,
  input  wire logic        array_prog,
  input  wire logic [7:0]  array_wdata,
  input  wire logic        array_erase,
  input  wire logic [18:0] array_erase_first,
  input  wire logic [18:0] array_erase_last
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem [0:524287];
  assign array_rdata = mem[array_addr];
  initial begin
    for (int i = 0; i < 524288; i++) begin
      mem[i] = 8'hff;
    end
  end
  always @(posedge clock) begin
    if (array_prog) begin
      mem[array_addr] <= array_wdata;
    end
    if (array_erase) begin
      for (int i = int'(array_erase_first); i <= int'(array_erase_last); i++) begin
        mem[i] <= 8'hff;
      end
    end
  end
endmodule // fcse_array_model
`default_nettype wire

// File: bench/flash_command_status_engine_tb.sv
// Self-checking bench of the flash command and status engine: table steps, then corner tests.
// Assumes the array model beside the engine and an erase time shortened to 50 cycles.
`default_nettype none
module flash_command_status_engine_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [1:0] W = 2'h0, R = 2'h1, B = 2'h2;
  localparam logic P = 1'b0, S = 1'b1;
  typedef struct packed {logic [1:0] op; logic port; logic [18:0] a; logic [7:0] d;} fcse_step_t;
  logic clock, reset, par_write, par_read, ser_write, ser_read, read_valid, tbl_n, gp_n;
  logic [18:0] par_addr, ser_addr, array_addr, first, last;
  logic [7:0] par_wdata, ser_wdata, read_data, array_rdata, array_wdata;
  logic [10:0] write_lock;
  logic array_prog, array_erase, rb_o, rb_oe;
  fcse_pkg::fcse_mode_t read_mode;
  int n_fail, total_checks, cycles, n_valid, saved;
  fcse_step_t rows [$] = '{
    '{R,P,19'h12345,8'hff}, '{W,P,19'h12345,8'h40}, '{W,P,19'h12345,8'ha5}, '{B,P,19'h0,8'h0},
    '{R,P,19'h00000,8'h80}, '{W,P,19'h00000,8'hff}, '{R,P,19'h12345,8'ha5}, '{W,S,19'h0,8'h10},
    '{W,S,19'h12345,8'h0f}, '{B,P,19'h0,8'h0}, '{W,S,19'h00000,8'hff}, '{R,S,19'h12345,8'h05},
    '{W,P,19'h00100,8'h40}, '{W,P,19'h00100,8'h00}, '{B,P,19'h0,8'h0}, '{W,P,19'h02100,8'h40},
    '{W,P,19'h02100,8'h00}, '{B,P,19'h0,8'h0}, '{W,P,19'h02000,8'h21}, '{W,P,19'h02000,8'hd0},
    '{B,P,19'h0,8'h0}, '{W,P,19'h00000,8'hff}, '{R,P,19'h02100,8'hff}, '{R,P,19'h00100,8'h00},
    '{W,P,19'h03000,8'h20}, '{W,P,19'h03000,8'hd0}, '{B,P,19'h0,8'h0}, '{W,P,19'h0,8'hff},
    '{R,P,19'h00100,8'hff}, '{W,P,19'h20000,8'h40}, '{W,P,19'h20000,8'h00}, '{B,P,19'h0,8'h0},
    '{W,P,19'h1ffff,8'h20}, '{W,P,19'h1ffff,8'hd0}, '{B,P,19'h0,8'h0}, '{W,P,19'h0,8'hff},
    '{R,P,19'h12345,8'hff}, '{R,P,19'h20000,8'h00}, '{W,P,19'h0,8'h90}, '{R,P,19'h0,8'h5a},
    '{R,P,19'h1,8'h3c}, '{R,P,19'h2,8'h00}, '{W,P,19'h0,8'h70}, '{R,P,19'h0,8'h80},
    '{W,P,19'h0,8'h20}, '{W,P,19'h0,8'h77}, '{R,P,19'h0,8'hb0}, '{W,P,19'h0,8'h50},
    '{W,P,19'h0,8'h70}, '{R,P,19'h0,8'h80}};
  fcse_top #(.ERASE_TIME_US(2)) fcse_top_i (
    .clock(clock), .reset(reset), .par_write(par_write), .par_read(par_read),
    .par_addr(par_addr), .par_wdata(par_wdata), .ser_write(ser_write), .ser_read(ser_read),
    .ser_addr(ser_addr), .ser_wdata(ser_wdata), .read_valid(read_valid),
    .read_data(read_data), .read_mode(read_mode), .write_lock(write_lock),
    .top_boot_protect_pin_n(tbl_n), .general_protect_pin_n(gp_n), .array_addr(array_addr),
    .array_rdata(array_rdata), .array_prog(array_prog), .array_wdata(array_wdata),
    .array_erase(array_erase), .array_erase_first(first), .array_erase_last(last),
    .ready_busy_output_o(rb_o), .ready_busy_output_oe(rb_oe));
  fcse_array_model fcse_array_model_i (
    .clock(clock), .array_addr(array_addr), .array_rdata(array_rdata),
    .array_prog(array_prog), .array_wdata(array_wdata), .array_erase(array_erase),
    .array_erase_first(first), .array_erase_last(last));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic strobe(input logic port, input logic rd, input logic [18:0] a,
                        input logic [7:0] d);
    @(negedge clock);
    par_addr = a;
    ser_addr = a;
    par_wdata = d;
    ser_wdata = d;
    par_write = !port && !rd;
    par_read = !port && rd;
    ser_write = port && !rd;
    ser_read = port && rd;
    @(negedge clock);
    {par_write, par_read, ser_write, ser_read} = 4'h0;
  endtask
  // Serial steps leave 18 cycles so the next access respects the bus cycle length.
  task automatic do_step(input fcse_step_t s);
    int k;
    k = 0;
    if (s.op == B) begin
      repeat (3) @(negedge clock);
      check({7'h00, rb_oe}, 8'h01, "busy pin during operation");
      while (rb_oe !== 1'b0 && k < 1000) begin
        @(negedge clock);
        k++;
      end
      check({7'h00, rb_oe}, 8'h00, "busy pin released");
    end else begin
      strobe(s.port, s.op == R, s.a, s.d);
      while (s.op == R && read_valid !== 1'b1 && k < 4) begin
        @(negedge clock);
        k++;
      end
      if (s.op == R) begin
        check({7'h00, read_valid}, 8'h01, "read answered");
        check(read_data, s.d, "read data");
      end
      if (s.port == S) repeat (18) @(negedge clock);
    end
  endtask
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  always @(posedge clock) begin
    cycles++;
    if (read_valid === 1'b1) n_valid++;
    if (cycles == 30000) begin
      n_fail++;
      final_report();
    end
  end
  initial begin
    {par_write, par_read, ser_write, ser_read, reset, tbl_n, gp_n} = 7'h07;
    {par_addr, ser_addr, par_wdata, ser_wdata, write_lock} = 65'h0;
    repeat (4) @(negedge clock);
    reset = 1'b0;
    check({6'h00, read_mode}, 8'h00, "mode after reset");
    foreach (rows[i]) do_step(rows[i]);
    $display("test table done");
    do_step('{W, P, 19'h30000, 8'h21});
    do_step('{W, P, 19'h30000, 8'hd0});
    do_step('{W, P, 19'h00000, 8'hff});
    do_step('{R, P, 19'h00000, 8'h00});
    do_step('{B, P, 19'h00000, 8'h00});
    do_step('{R, P, 19'h00000, 8'h80});
    $display("test busy done");
    write_lock = 11'h004;
    do_step('{W, P, 19'h04000, 8'h40});
    do_step('{W, P, 19'h04000, 8'h00});
    do_step('{R, P, 19'h00000, 8'h92});
    check({7'h00, rb_oe}, 8'h00, "no busy when refused");
    do_step('{W, P, 19'h00000, 8'h50});
    write_lock = 11'h008;
    do_step('{W, P, 19'h00000, 8'h20});
    do_step('{W, P, 19'h00000, 8'hd0});
    do_step('{R, P, 19'h00000, 8'ha2});
    do_step('{W, P, 19'h00000, 8'h50});
    write_lock = 11'h000;
    tbl_n = 1'b0;
    do_step('{W, P, 19'h70000, 8'h40});
    do_step('{W, P, 19'h70000, 8'h00});
    do_step('{R, P, 19'h00000, 8'h92});
    do_step('{W, P, 19'h00000, 8'h50});
    tbl_n = 1'b1;
    do_step('{W, P, 19'h00000, 8'hff});
    do_step('{R, P, 19'h04000, 8'hff});
    $display("test protection done");
    strobe(S, 1'b0, 19'h00000, 8'h90);
    repeat (5) @(negedge clock);
    strobe(S, 1'b0, 19'h00000, 8'hff);
    repeat (18) @(negedge clock);
    do_step('{R, S, 19'h00001, 8'h3c});
    saved = n_valid;
    strobe(S, 1'b1, 19'h00000, 8'h00);
    repeat (5) @(negedge clock);
    strobe(S, 1'b1, 19'h00001, 8'h00);
    repeat (30) @(negedge clock);
    check(8'(n_valid - saved), 8'h01, "serial reads answered");
    $display("test serial spacing done");
    reset = 1'b1;
    repeat (4) @(negedge clock);
    reset = 1'b0;
    check({6'h00, read_mode}, 8'h00, "mode after second reset");
    do_step('{R, P, 19'h00000, 8'hff});
    $display("test reset done");
    final_report();
  end
endmodule // flash_command_status_engine_tb
`default_nettype wire
